// >>> src/sealer_cyclic_control_status.sv
// cyclic command interpreter and status formatter of a sealing controller
// assumes an apb master on pclk and a measurement/fault front end
// that presents readings and fault indications synchronous to pclk
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "sealer_map.svh"

module sealer_cyclic_control_status #(
    parameter int INIT_CYCLES = `INIT_TIME_MS * `CLK_FREQ_KHZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] temp_in,
    input  wire logic        temp_valid,
    input  wire logic        fault_full_in,
    input  wire logic        fault_57_in,
    input  wire logic [9:0]  err_code_in,
    input  wire logic [3:0]  err_short_in,
    input  wire logic        warn_in,
    input  wire logic        cooling_in,
    input  wire logic        systest_ok_in,
    input  wire logic        cal_done_in,
    output logic             heat_en,
    output logic             impulse_en,
    output logic             relay_on,
    output logic             cal_en,
    output logic             param_req,
    output logic             ctrl_reset
);
    logic [3:0]  ctrl_r;
    logic [15:0] setpoint_r;
    logic [31:0] config_r;
    sealer_pkg::mode_t state_r;
    sealer_pkg::mode_t state_nxt;
    logic        alarm_r;
    logic [9:0]  code_r;
    logic [3:0]  code4_r;
    logic [15:0] actual_r;
    logic        test_ok_r;
    logic        heat_d_r;
    logic        target_r;
    logic        win_r;
    logic [31:0] init_cnt_r;
    logic [15:0] word1_r;
    logic [15:0] word2_r;

    logic heat_cmd;
    logic cal_cmd;
    logic clr_cmd;
    logic pause_cmd;
    assign cal_cmd   = ctrl_r[`CTRL_CAL_POS];
    assign heat_cmd  = ctrl_r[`CTRL_HEAT_POS];
    assign clr_cmd   = ctrl_r[`CTRL_CLR_POS];
    assign pause_cmd = ctrl_r[`CTRL_PAUSE_POS];

    logic range_high;
    logic code10;
    logic ext_fmt;
    sealer_pkg::win_mode_t win_mode;
    assign range_high = config_r[`CFG_RANGE_POS];
    assign code10     = config_r[`CFG_CODE10_POS];
    assign ext_fmt    = config_r[`CFG_EXT_POS];
    assign win_mode   =
        sealer_pkg::win_mode_t'(config_r[`CFG_WIN_LSB +: 2]);

    // apb access decode; every access completes in its first access cycle
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    logic [15:0] sp_max;
    logic [15:0] sp_eff;
    assign sp_max = range_high ? `TMAX_HIGH : `TMAX_LOW;
    assign sp_eff = (setpoint_r > sp_max) ? sp_max : setpoint_r;

    // reading gates
    logic measuring;
    logic pause_eff;
    logic full_eval;
    assign measuring = (state_r == sealer_pkg::ST_IDLE) && !heat_cmd
                       && !cal_cmd && !clr_cmd;
    assign pause_eff = pause_cmd && measuring && test_ok_r;
    assign full_eval = (state_r != sealer_pkg::ST_CLEAR) && !pause_eff;

    logic cal_block;
    assign cal_block = heat_cmd || cooling_in || clr_cmd || alarm_r
                       || state_r == sealer_pkg::ST_INIT;

    logic heat_rise;
    logic warn_trip;
    assign heat_rise = heat_cmd && !heat_d_r;
    assign warn_trip = heat_rise && warn_in;

    logic init_done;
    assign init_done = (init_cnt_r == 32'(INIT_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == `CTRL_OFS
                || paddr == `SETPOINT_OFS || paddr == `CONFIG_OFS
                || paddr == `WORD1_OFS || paddr == `WORD2_OFS
                || paddr == `DIAG_OFS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= 4'h0;
            setpoint_r <= 16'h0000;
            config_r   <= `CFG_RESET;
        end else if (wr_en) begin
            case (paddr)
                `CTRL_OFS:     ctrl_r     <= pwdata[3:0];
                `SETPOINT_OFS: setpoint_r <= pwdata[15:0];
                `CONFIG_OFS:   config_r   <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `CTRL_OFS:     prdata <= {28'h0, ctrl_r};
                `SETPOINT_OFS: prdata <= {16'h0, setpoint_r};
                `CONFIG_OFS:   prdata <= config_r;
                `WORD1_OFS:    prdata <= {16'h0, word1_r};
                `WORD2_OFS:    prdata <= {16'h0, word2_r};
                `DIAG_OFS:     prdata <= {28'h0, code4_r};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sealer_pkg::ST_IDLE: begin
                if (clr_cmd) begin
                    state_nxt = sealer_pkg::ST_CLEAR;
                end else if (heat_cmd && !alarm_r && !warn_trip) begin
                    state_nxt = sealer_pkg::ST_REG;
                end else if (cal_cmd && !cal_block) begin
                    state_nxt = sealer_pkg::ST_CAL;
                end
            end
            sealer_pkg::ST_REG: begin
                if (clr_cmd) begin
                    state_nxt = sealer_pkg::ST_CLEAR;
                end else if (!heat_cmd || alarm_r) begin
                    state_nxt = sealer_pkg::ST_IDLE;
                end
            end
            sealer_pkg::ST_CAL: begin
                if (cal_done_in) begin
                    state_nxt = clr_cmd ? sealer_pkg::ST_CLEAR
                                        : sealer_pkg::ST_IDLE;
                end
            end
            sealer_pkg::ST_CLEAR: begin
                if (!clr_cmd) begin
                    state_nxt = sealer_pkg::ST_INIT;
                end
            end
            sealer_pkg::ST_INIT: begin
                if (clr_cmd) begin
                    state_nxt = sealer_pkg::ST_CLEAR;
                end else if (init_done) begin
                    state_nxt = sealer_pkg::ST_IDLE;
                end
            end
            default: state_nxt = sealer_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= sealer_pkg::ST_IDLE;
            heat_d_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            heat_d_r <= heat_cmd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_r <= 32'h0000_0000;
        end else if (state_r == sealer_pkg::ST_INIT && !init_done) begin
            init_cnt_r <= init_cnt_r + 32'h0000_0001;
        end else if (state_r != sealer_pkg::ST_INIT) begin
            init_cnt_r <= 32'h0000_0000;
        end
    end

    // system test pass is caught once after reset and kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_ok_r <= 1'b0;
        end else if (systest_ok_in) begin
            test_ok_r <= 1'b1;
        end
    end

    // alarm: a new fault wins over the reset that clears it
    logic alarm_set;
    assign alarm_set = fault_57_in || (full_eval && fault_full_in)
                       || warn_trip;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_r <= 1'b0;
            code_r  <= 10'h000;
            code4_r <= 4'h0;
        end else if (alarm_set) begin
            alarm_r <= 1'b1;
            code_r  <= err_code_in;
            code4_r <= err_short_in;
        end else if (state_r == sealer_pkg::ST_CLEAR && !clr_cmd) begin
            alarm_r <= 1'b0;
            code_r  <= 10'h000;
            code4_r <= 4'h0;
        end
    end

    // actual value: frozen under pause, forced low under fault clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            actual_r <= 16'h0000;
        end else if (clr_cmd || state_r == sealer_pkg::ST_CLEAR) begin
            actual_r <= 16'h0000;
        end else if (temp_valid && !pause_eff) begin
            actual_r <= temp_in;
        end
    end

    logic signed [24:0] act_scaled;
    logic signed [24:0] sp_scaled;
    logic signed [17:0] act_w;
    logic signed [17:0] lo_lim;
    logic signed [17:0] hi_lim;
    logic in_win;
    assign act_w  = 18'(signed'(actual_r));
    assign act_scaled = 25'(act_w) * 25'(`PCT_DEN);
    assign sp_scaled  = 25'(signed'({2'b00, sp_eff})) * 25'(`PCT_NUM);
    assign lo_lim = 18'(sp_eff) - 18'(config_r[`CFG_LO_LSB +: 8]);
    assign hi_lim = 18'(sp_eff) + 18'(config_r[`CFG_HI_LSB +: 8]);
    assign in_win = (act_w >= lo_lim) && (act_w <= hi_lim);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_r <= 1'b0;
        end else if (!heat_cmd || alarm_r) begin
            target_r <= 1'b0;
        end else if (state_r == sealer_pkg::ST_REG) begin
            target_r <= act_scaled > sp_scaled;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_r <= 1'b0;
        end else begin
            case (win_mode)
                sealer_pkg::WIN_PLAIN: win_r <= in_win;
                sealer_pkg::WIN_LATCH: begin
                    if (heat_rise) begin
                        win_r <= in_win;
                    end else if (heat_cmd) begin
                        win_r <= in_win;
                    end
                end
                default: win_r <= 1'b0;
            endcase
        end
    end

    // cyclic output words
    logic cal_run;
    logic regulating;
    logic [15:0] mag;
    assign cal_run    = state_r == sealer_pkg::ST_CAL;
    assign regulating = state_r == sealer_pkg::ST_REG;
    assign mag = actual_r[15] ? 16'(-actual_r) : actual_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word1_r <= 16'h0000;
            word2_r <= 16'h0000;
        end else begin
            word2_r[15:6] <= (ext_fmt && code10) ? code_r : 10'h000;
            if (!(ext_fmt && code10)) begin
                word2_r[11:8] <= code4_r;
            end
            word2_r[5:0] <= {cal_run, cal_block, alarm_r,
                             target_r, win_r, regulating};
            if (ext_fmt) begin
                word1_r <= (cal_run || alarm_r) ? 16'h0000
                                                 : actual_r;
            end else if (alarm_r) begin
                word1_r <= code10 ? {6'h00, code_r}
                                  : {12'h000, code4_r};
            end else begin
                word1_r <= {actual_r[15], mag[14:0]};
            end
        end
    end

    // power stage and front-end controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heat_en    <= 1'b0;
            impulse_en <= 1'b0;
            relay_on   <= 1'b0;
            cal_en     <= 1'b0;
            param_req  <= 1'b0;
            ctrl_reset <= 1'b0;
        end else begin
            heat_en    <= state_nxt == sealer_pkg::ST_REG
                          && !alarm_set;
            impulse_en <= state_nxt != sealer_pkg::ST_CLEAR
                          && !clr_cmd && !pause_eff;
            relay_on   <= alarm_set || alarm_r;
            cal_en     <= state_nxt == sealer_pkg::ST_CAL;
            param_req  <= state_r == sealer_pkg::ST_CLEAR
                          && !clr_cmd;
            ctrl_reset <= state_r == sealer_pkg::ST_CLEAR && !clr_cmd;
        end
    end
endmodule

// >>> src/sealer_map.svh
// register offsets, field positions, reset values and timing figures
// assumes a 32-bit apb slave with byte addresses
`ifndef SEALER_MAP_SVH
`define SEALER_MAP_SVH

`define CTRL_OFS       8'h00
`define SETPOINT_OFS   8'h04
`define CONFIG_OFS     8'h08
`define WORD1_OFS      8'h0c
`define WORD2_OFS      8'h10
`define DIAG_OFS       8'h14

`define CTRL_CAL_POS   0
`define CTRL_HEAT_POS  1
`define CTRL_CLR_POS   2
`define CTRL_PAUSE_POS 3

`define CFG_RANGE_POS  0
`define CFG_WIN_LSB    1
`define CFG_CODE10_POS 3
`define CFG_EXT_POS    4
`define CFG_LO_LSB     8
`define CFG_HI_LSB     16
`define CFG_RESET      32'h000a_0a02

`define TMAX_LOW       16'h012c
`define TMAX_HIGH      16'h01f4
`define PCT_NUM        8'h13
`define PCT_DEN        8'h14

`define CLK_FREQ_KHZ   10000
`define INIT_TIME_MS   500

`endif

// >>> src/sealer_pkg.sv
// types shared by the cyclic command and status logic
package sealer_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REG,
        ST_CAL,
        ST_CLEAR,
        ST_INIT
    } mode_t;

    typedef enum logic [1:0] {
        WIN_OFF,
        WIN_PLAIN,
        WIN_LATCH
    } win_mode_t;
endpackage

// >>> tb/plc_model.sv
// fieldbus master stand-in: issues apb transfers for the bench
// assumes pclk from the bench; no loop contactor is modelled
`timescale 1ns/1ps
module plc_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e, output logic ok);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        ok = pready;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show no stale value
        paddr <= ~a;
        pwdata <= ~d;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// >>> tb/sealer_cyclic_control_status_tb.sv
// bench for the sealer cyclic command and status block
// assumes plc_model as apb master and sealer_monitor bound to the dut
`timescale 1ns/1ps
`include "sealer_map.svh"
module sealer_cyclic_control_status_tb;
    localparam int INIT_N = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ok;
    logic temp_valid, fault_full_in, fault_57_in, warn_in, cooling_in;
    logic systest_ok_in, cal_done_in, heat_en, impulse_en, relay_on;
    logic cal_en, param_req, ctrl_reset;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] temp_in, t;
    logic [9:0]  err_code_in;
    logic [3:0]  err_short_in;
    int n_errors = 0;
    int checks = 0;
    int n_rst = 0;

    sealer_cyclic_control_status #(.INIT_CYCLES(INIT_N)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .temp_in(temp_in),
        .temp_valid(temp_valid), .fault_full_in(fault_full_in),
        .fault_57_in(fault_57_in), .err_code_in(err_code_in),
        .err_short_in(err_short_in), .warn_in(warn_in),
        .cooling_in(cooling_in), .systest_ok_in(systest_ok_in),
        .cal_done_in(cal_done_in), .heat_en(heat_en),
        .impulse_en(impulse_en), .relay_on(relay_on), .cal_en(cal_en),
        .param_req(param_req), .ctrl_reset(ctrl_reset));

    plc_model plc (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (param_req === 1'b1 && ctrl_reset === 1'b1)
            n_rst++;
    end

    task automatic test_done();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, y);
        checks++;
        if (y !== x) begin
            $display("[ERR] %s expected %h seen %h", nm, x, y);
            n_errors++;
        end
    endtask

    task automatic go(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        plc.xfer(w, a, d, q, e, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, x,
                      input string nm);
        go(1'b0, a, 32'h0);
        chk(nm, x, q & m);
    endtask

    task automatic ctl(input logic [31:0] d);
        go(1'b1, `CTRL_OFS, d);
    endtask

    task automatic temp(input logic [15:0] v);
        temp_in <= v;
        temp_valid <= 1'b1;
        @(posedge pclk);
        temp_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    function automatic logic [31:0] cmp(input logic [15:0] v);
        return v[15] ? {17'h1, 15'(-v)} : {16'h0, v};
    endfunction

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        test_done();
    end

    initial begin
        presetn = 1'b0;
        {temp_in, err_code_in, err_short_in} = '0;
        {temp_valid, fault_full_in, fault_57_in, warn_in} = '0;
        {cooling_in, systest_ok_in, cal_done_in} = '0;
        void'($urandom(47));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(`CONFIG_OFS, '1, 32'h000a_0a02, "cfg_reset");
        go(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        temp(16'h0064);
        ctl(32'h8);
        chk("pause_early", 32'h1, 32'(impulse_en));
        systest_ok_in <= 1'b1;
        err_code_in <= 10'h2a5;
        err_short_in <= 4'h9;
        @(posedge pclk);
        temp(16'h0050);
        chk("pause_imp", 32'h0, 32'(impulse_en));
        rd(`WORD1_OFS, 32'hffff, 32'h64, "pause_hold");
        fault_full_in <= 1'b1;
        temp(16'h0050);
        fault_full_in <= 1'b0;
        rd(`WORD2_OFS, 32'h8, 32'h0, "pause_full");
        fault_57_in <= 1'b1;
        temp(16'h0050);
        fault_57_in <= 1'b0;
        ctl(32'h0);
        chk("resume_imp", 32'h1, 32'(impulse_en));
        rd(`WORD2_OFS, 32'h8, 32'h8, "alarm_kept");
        rd(`DIAG_OFS, 32'hf, 32'h9, "diag");
        rd(`WORD1_OFS, 32'hffff, 32'h9, "code4");
        go(1'b1, `CONFIG_OFS, 32'h000a_0a0a);
        rd(`WORD1_OFS, 32'hffff, 32'h2a5, "code10");
        go(1'b1, `CONFIG_OFS, 32'h000a_0a1a);
        rd(`WORD1_OFS, 32'hffff, 32'h0, "ext_zero");
        rd(`WORD2_OFS, 32'hffc0, 32'ha940, "ext10");
        go(1'b1, `CONFIG_OFS, 32'h000a_0a12);
        rd(`WORD2_OFS, 32'hf00, 32'h900, "ext4");
        ctl(32'h2);
        chk("alarm_heat", 32'h0, 32'(heat_en));
        ctl(32'h4);
        chk("clr_imp", 32'h0, 32'(impulse_en));
        ctl(32'h6);
        chk("clr_noheat", 32'h0, 32'(heat_en));
        ctl(32'h2);
        chk("rst_pulse", 32'h1, 32'(n_rst));
        chk("init_heat", 32'h0, 32'(heat_en));
        rd(`WORD2_OFS, 32'h8, 32'h0, "alarm_clr");
        repeat (INIT_N + 5) @(posedge pclk);
        go(1'b1, `CONFIG_OFS, 32'h000a_0a02);
        go(1'b1, `SETPOINT_OFS, 32'h0400);
        ctl(32'h2);
        chk("heat_on", 32'h1, 32'(heat_en));
        temp(16'h012c);
        rd(`WORD2_OFS, 32'h3f, 32'h17, "heat_stat");
        cooling_in <= 1'b1;
        ctl(32'h0);
        rd(`WORD2_OFS, 32'h3f, 32'h12, "idle_stat");
        cooling_in <= 1'b0;
        go(1'b1, `CONFIG_OFS, 32'h000a_0a04);
        ctl(32'h2);
        temp(16'h012c);
        ctl(32'h0);
        temp(16'h0000);
        rd(`WORD2_OFS, 32'h2, 32'h2, "latch_hold");
        ctl(32'h2);
        rd(`WORD2_OFS, 32'h2, 32'h0, "latch_new");
        ctl(32'h0);
        go(1'b1, `CONFIG_OFS, 32'h000a_0a00);
        temp(16'h012c);
        rd(`WORD2_OFS, 32'h2, 32'h0, "win_off");
        warn_in <= 1'b1;
        ctl(32'h2);
        chk("trip_relay", 32'h1, 32'(relay_on));
        chk("trip_heat", 32'h0, 32'(heat_en));
        warn_in <= 1'b0;
        ctl(32'h4);
        ctl(32'h0);
        repeat (INIT_N + 5) @(posedge pclk);
        ctl(32'h1);
        rd(`WORD2_OFS, 32'h20, 32'h20, "cal_flag");
        ctl(32'h3);
        chk("cal_heat", 32'h0, 32'(heat_en));
        ctl(32'h4);
        chk("cal_keep", 32'h1, 32'(cal_en));
        rd(`WORD1_OFS, 32'hffff, 32'h0, "clr_zero");
        cal_done_in <= 1'b1;
        @(posedge pclk);
        cal_done_in <= 1'b0;
        ctl(32'h0);
        repeat (INIT_N + 5) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            t = 16'($urandom_range(1000)) - 16'd500;
            go(1'b1, `CONFIG_OFS, 32'h000a_0a02);
            temp(t);
            rd(`WORD1_OFS, 32'hffff, cmp(t), "compact");
            go(1'b1, `CONFIG_OFS, 32'h000a_0a12);
            rd(`WORD1_OFS, 32'hffff, {16'h0, t}, "extended");
        end
        test_done();
    end
endmodule

// >>> tb/sealer_monitor.sv
// port assertions for the sealer cyclic command and status block
// assumes a bind onto sealer_cyclic_control_status, one pclk domain
`timescale 1ns/1ps
module sealer_monitor #(
    parameter int INIT_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic heat_en,
    input wire logic impulse_en,
    input wire logic relay_on,
    input wire logic cal_en,
    input wire logic param_req,
    input wire logic ctrl_reset,
    input wire logic cal_done_in
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    int unsigned hold_c;

    // counts down the initialization run after a controller reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hold_c <= 0;
        else if (ctrl_reset)
            hold_c <= INIT_CYCLES;
        else if (hold_c != 0)
            hold_c <= hold_c - 1;
    end

    chk_heat_nocal: assert property (heat_en |-> !cal_en)
        else $error("heating during calibration");
    chk_relay_cold: assert property (relay_on |-> !heat_en)
        else $error("heating with relay tripped");
    chk_clear_dark: assert property (ctrl_reset |->
        !$past(impulse_en) && !$past(heat_en))
        else $error("power or impulses during fault clear");
    chk_reset_pair: assert property (ctrl_reset |->
        param_req ##1 !(ctrl_reset || param_req))
        else $error("reset and parameter request not one pulse");
    chk_cal_finish: assert property ($fell(cal_en) |->
        $past(cal_done_in) || $past(cal_done_in, 2))
        else $error("calibration ended without done");
    chk_init_wait: assert property (hold_c > 1 |-> !heat_en)
        else $error("heating during initialization");
    chk_ans_next: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_one: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");

    cover property ($rose(heat_en));
    cover property (ctrl_reset);
    cover property ($fell(cal_en));
    cover property (relay_on);
endmodule

bind sealer_cyclic_control_status sealer_monitor #(
    .INIT_CYCLES(INIT_CYCLES)
) mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .heat_en(heat_en),
    .impulse_en(impulse_en), .relay_on(relay_on), .cal_en(cal_en),
    .param_req(param_req), .ctrl_reset(ctrl_reset),
    .cal_done_in(cal_done_in));
